// ==== design/tap_i2c_slave.sv ====
// Two-wire slave port of the touch digitiser: framing, addressing, ack and stretching.
`timescale 1ns/1ps
`default_nettype none

module tap_i2c_slave (
  // System
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  // Two-wire bus clock line
  input  wire logic                      scl_in,
  output logic                           scl_out,
  output logic                           scl_oe,
  // Two-wire bus data line
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  // Address-select pins
  input  wire logic                      addr_select_hi_pin,
  input  wire logic                      addr_select_lo_pin,
  // Received bytes
  output logic [tap_pkg::BYTE_W-1:0]     rx_data,
  output logic                           rx_valid,
  // Bytes to send
  input  wire logic [tap_pkg::BYTE_W-1:0] tx_data,
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  // Transfer status
  output logic                           xfer_start,
  output logic                           xfer_end,
  output logic                           selected,
  output logic                           read_mode,
  output logic                           hs_mode
);
  import tap_pkg::*;

  // ==========================================================================
  // Line synchronisers and glitch filters
  logic [1:0]              line_meta;
  logic [1:0]              line_sync;
  logic [1:0]              line_filt;
  logic [1:0]              line_filt_q;
  logic [GLITCH_CNT_W-1:0] line_cnt [2];
  logic [1:0]              pin_meta;
  logic [1:0]              pin_sync;
  wire  [1:0]              line_raw;

  localparam logic [GLITCH_CNT_W-1:0] GLITCH_LAST = GLITCH_CNT_W'(GLITCH_CYC - 1);

  assign line_raw[LINE_SCL] = scl_in;
  assign line_raw[LINE_SDA] = sda_in;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      line_meta <= 2'h3;
      line_sync <= 2'h3;
      pin_meta  <= 2'h0;
      pin_sync  <= 2'h0;
    end else begin
      line_meta <= line_raw;
      line_sync <= line_meta;
      pin_meta  <= {addr_select_hi_pin, addr_select_lo_pin};
      pin_sync  <= pin_meta;
    end
  end

  // filter short enough for every bus rate.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      line_filt   <= 2'h3;
      line_filt_q <= 2'h3;
      for (int i = 0; i < 2; i++) begin
        line_cnt[i] <= '0;
      end
    end else begin
      line_filt_q <= line_filt;
      for (int i = 0; i < 2; i++) begin
        if (line_sync[i] == line_filt[i]) begin
          line_cnt[i] <= '0;
        end else if (line_cnt[i] == GLITCH_LAST) begin
          line_filt[i] <= line_sync[i];
          line_cnt[i]  <= '0;
        end else begin
          line_cnt[i] <= line_cnt[i] + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Bus event decode
  wire scl_h    = line_filt[LINE_SCL];
  wire sda_h    = line_filt[LINE_SDA];
  wire scl_was  = line_filt_q[LINE_SCL];
  wire sda_was  = line_filt_q[LINE_SDA];
  wire scl_rise = scl_h & ~scl_was;
  wire scl_fall = ~scl_h & scl_was;

  wire start_cond = scl_h & scl_was & sda_was & ~sda_h;
  wire stop_cond  = scl_h & scl_was & ~sda_was & sda_h;

  // ==========================================================================
  // Sequencer registers
  tap_state_t          state;
  tap_state_t          next_state;
  logic [CNT_W-1:0]    bit_cnt;
  logic [CNT_W-1:0]    next_bit_cnt;
  logic [BYTE_W-1:0]   shreg;
  logic [BYTE_W-1:0]   next_shreg;
  logic                nack;
  logic                next_nack;
  logic                hs_arm;
  logic                next_hs_arm;
  logic                next_hs_mode;
  logic                next_sda_oe;
  logic                next_scl_oe;
  logic [BYTE_W-1:0]   next_rx_data;
  logic                next_rx_valid;
  logic                next_tx_ready;
  logic                next_xfer_start;
  logic                next_xfer_end;
  logic                next_selected;
  logic                next_read_mode;

  // own address from fixed bits and select pins.
  // select pins are read live at each address byte.
  wire [6:0] own_addr  = {ADDR_FIXED, pin_sync};
  wire       byte_done = scl_fall & (bit_cnt == BYTE_BITS);
  wire       addr_hit  = (shreg[ADDR_HI_POS:1] == own_addr);
  wire       mcode_hit = (shreg[ADDR_HI_POS:ADDR_LO_POS] == MCODE_PFX);
  wire [BYTE_W-1:0] shifted = {shreg[BYTE_W-2:0], sda_h};
  wire [CNT_W-1:0]  cnt_inc = bit_cnt + 1'b1;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    next_state      = state;
    next_bit_cnt    = bit_cnt;
    next_shreg      = shreg;
    next_nack       = nack;
    next_hs_arm     = hs_arm;
    next_hs_mode    = hs_mode;
    next_sda_oe     = sda_oe;
    next_scl_oe     = scl_oe;
    next_rx_data    = rx_data;
    next_rx_valid   = 1'b0;
    next_tx_ready   = 1'b0;
    next_xfer_start = 1'b0;
    next_xfer_end   = 1'b0;
    next_selected   = selected;
    next_read_mode  = read_mode;
    if (stop_cond) begin
      next_state    = TAP_IDLE;
      next_sda_oe   = 1'b0;
      next_scl_oe   = 1'b0;
      next_selected = 1'b0;
      next_xfer_end = (state != TAP_IDLE);
      next_hs_mode  = 1'b0;
      next_hs_arm   = 1'b0;
    end else if (start_cond) begin
      // repeated START ends one transfer and opens the next.
      next_state      = TAP_ADDR;
      next_bit_cnt    = '0;
      next_sda_oe     = 1'b0;
      next_scl_oe     = 1'b0;
      next_selected   = 1'b0;
      next_xfer_start = 1'b1;
      next_xfer_end   = (state != TAP_IDLE);
      // high-speed entered at the START after a master code.
      if (hs_arm) begin
        next_hs_mode = 1'b1;
        next_hs_arm  = 1'b0;
      end
    end else begin
      case (state)
        TAP_ADDR, TAP_RX: begin
          if (scl_rise) begin
            next_shreg   = shifted;
            next_bit_cnt = cnt_inc;
          end
          if (byte_done) begin
            next_bit_cnt = '0;
            if (state == TAP_RX) begin
              next_rx_data  = shreg;
              next_rx_valid = 1'b1;
              next_sda_oe   = 1'b1;
              next_state    = TAP_ACK;
            end else if (mcode_hit) begin
              next_hs_arm = 1'b1;
              next_state  = TAP_IGNORE;
            end else if (addr_hit) begin
              // direction bit selects read or write.
              next_read_mode = (shreg[RW_POS] == RW_READ);
              next_selected  = 1'b1;
              next_sda_oe    = 1'b1;
              next_state     = TAP_ACK;
            end else begin
              next_state = TAP_IGNORE;
            end
          end
        end
        TAP_ACK: begin
          // hold ack low until the ninth clock falls.
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            // take the next byte in a write, or load a byte to send in a read.
            next_state  = read_mode ? TAP_LOAD : TAP_RX;
          end
        end
        TAP_LOAD: begin
          if (tx_valid) begin
            next_shreg    = tx_data;
            next_tx_ready = 1'b1;
            next_sda_oe   = ~tx_data[BYTE_W-1];
            next_bit_cnt  = '0;
            next_state    = TAP_TX;
          end else begin
            // stretch SCL low until a byte is loaded.
            next_scl_oe = 1'b1;
          end
        end
        TAP_TX: begin
          // first bit settles before the clock is let go.
          next_scl_oe = 1'b0;
          if (scl_rise) begin
            next_bit_cnt = cnt_inc;
          end
          // drive the next bit only after SCL falls.
          if (byte_done) begin
            next_sda_oe = 1'b0;
            next_state  = TAP_TXACK;
          end else if (scl_fall) begin
            next_shreg  = {shreg[BYTE_W-2:0], 1'b0};
            next_sda_oe = ~shreg[BYTE_W-2];
          end
        end
        TAP_TXACK: begin
          if (scl_rise) begin
            next_nack = sda_h;
          end
          if (scl_fall) begin
            next_state = nack ? TAP_IGNORE : TAP_LOAD;
          end
        end
        TAP_IDLE, TAP_IGNORE: begin
          next_sda_oe = 1'b0;
          next_scl_oe = 1'b0;
        end
        default: begin
          next_state = TAP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Sequencer and output registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state      <= TAP_IDLE;
      bit_cnt    <= '0;
      shreg      <= '0;
      nack       <= 1'b0;
      hs_arm     <= 1'b0;
      hs_mode    <= 1'b0;
      sda_oe     <= 1'b0;
      scl_oe     <= 1'b0;
      rx_data    <= '0;
      rx_valid   <= 1'b0;
      tx_ready   <= 1'b0;
      xfer_start <= 1'b0;
      xfer_end   <= 1'b0;
      selected   <= 1'b0;
      read_mode  <= 1'b0;
    end else begin
      state      <= next_state;
      bit_cnt    <= next_bit_cnt;
      shreg      <= next_shreg;
      nack       <= next_nack;
      hs_arm     <= next_hs_arm;
      hs_mode    <= next_hs_mode;
      sda_oe     <= next_sda_oe;
      scl_oe     <= next_scl_oe;
      rx_data    <= next_rx_data;
      rx_valid   <= next_rx_valid;
      tx_ready   <= next_tx_ready;
      xfer_start <= next_xfer_start;
      xfer_end   <= next_xfer_end;
      selected   <= next_selected;
      read_mode  <= next_read_mode;
    end
  end

  // open-drain pins only ever pull low.
  always_ff @(posedge core_clk) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

endmodule

`default_nettype wire

// ==== design/tap_pkg.sv ====
// Constants and types shared by the touch digitiser two-wire slave port.
package tap_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int GLITCH_NS     = 40;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CNT_W  = 3;

  // ==========================================================================
  // Bus rates served, in kHz
  localparam int STD_RATE_KHZ  = 100;
  localparam int FAST_RATE_KHZ = 400;
  localparam int HS_LO_KHZ     = 1700;
  localparam int HS_RATE_KHZ   = 3400;

  // ==========================================================================
  // Byte framing
  localparam int         BYTE_W    = 8;
  localparam int         CNT_W     = 4;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ==========================================================================
  // Address byte layout
  localparam logic [4:0] ADDR_FIXED = 5'h12;
  localparam logic [4:0] MCODE_PFX  = 5'h01;
  localparam int         ADDR_HI_POS = 7;
  localparam int         ADDR_LO_POS = 3;
  localparam int         RW_POS     = 0;
  localparam logic       RW_READ    = 1'h1;

  // ==========================================================================
  // Line indices into the synchroniser arrays
  localparam int LINE_SCL = 0;
  localparam int LINE_SDA = 1;

  // ==========================================================================
  // Port sequencing states
  typedef enum logic [2:0] {
    TAP_IDLE,
    TAP_ADDR,
    TAP_RX,
    TAP_ACK,
    TAP_LOAD,
    TAP_TX,
    TAP_TXACK,
    TAP_IGNORE
  } tap_state_t;

endpackage

// ==== dv/tap_i2c_slave_asserts.sv ====
// Property checker for the two-wire slave port.
`timescale 1ns/1ps
`default_nettype none

module tap_i2c_slave_asserts (
  // System
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Bus lines
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  // Straps and user side
  input wire logic       addr_select_hi_pin,
  input wire logic       addr_select_lo_pin,
  input wire logic [7:0] rx_data,
  input wire logic       rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       xfer_start,
  input wire logic       xfer_end,
  input wire logic       selected,
  input wire logic       read_mode,
  input wire logic       hs_mode
);
  // ==========================================================================
  // Bus conditions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence start_seq; scl_in && $fell(sda_in); endsequence
  sequence stop_seq; scl_in && $rose(sda_in); endsequence

  // ==========================================================================
  // Properties
  a_pins_low: assert property (!scl_out && !sda_out)
    else $error("Driven level of a line is not low.");
  a_sda_steady: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("Data drive changed while clock high.");
  a_start_flag: assert property (start_seq |-> ##[1:8] xfer_start)
    else $error("Start condition not flagged.");
  a_stop_flag: assert property (selected ##0 stop_seq |-> ##[1:8] xfer_end)
    else $error("Stop condition did not end the transfer.");
  a_hs_drop: assert property (stop_seq |-> ##[1:8] !hs_mode)
    else $error("High-speed mode kept after stop.");
  a_rx_ack: assert property (rx_valid |-> ##[0:2] sda_oe)
    else $error("Received byte not acknowledged.");
  a_rx_dir: assert property (rx_valid |-> selected && !read_mode)
    else $error("Byte received outside a write.");
  a_tx_take: assert property (tx_ready |-> $past(tx_valid) && read_mode)
    else $error("Byte taken without valid data.");
  a_stretch_end: assert property (scl_oe && tx_valid |-> ##[1:3] !scl_oe)
    else $error("Clock held after data was ready.");
  a_stretch_read: assert property (scl_oe |-> selected && read_mode)
    else $error("Clock held outside a read.");
  a_quiet_unsel: assert property (!selected ##1 !selected |-> !$past(sda_oe))
    else $error("Data driven while not addressed.");
  a_tx_setup: assert property ($fell(scl_oe) |-> $stable(sda_oe))
    else $error("Data drive changed as the clock was released.");
endmodule

bind tap_i2c_slave tap_i2c_slave_asserts i_tap_i2c_slave_asserts (.*);

`default_nettype wire

// ==== dv/tap_master_model.sv ====
// Behavioural two-wire bus master driving the open-drain lines.
`timescale 1ns/1ps
`default_nettype none

module tap_master_model #(
  parameter int LO_CYC = 8,
  parameter int HI_CYC = 4,
  parameter int HS_HI_CYC = 3
) (
  input wire logic core_clk,
  input wire logic scl,
  input wire logic sda,
  output logic     scl_pull,
  output logic     sda_pull
);
  int hi_cyc = HI_CYC;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic set_hs(input logic on);
    hi_cyc = on ? HS_HI_CYC : HI_CYC;
  endtask
  task automatic rise_scl;
    int n;
    n = 0;
    scl_pull <= 1'b0;
    do begin
      @(negedge core_clk);
      n++;
    end while (scl !== 1'b1 && n < 2000);
    @(posedge core_clk);
  endtask
  task automatic start;
    sda_pull <= 1'b0;
    wait_cyc(LO_CYC);
    rise_scl();
    wait_cyc(hi_cyc / 2);
    sda_pull <= 1'b1;
    wait_cyc(hi_cyc / 2);
    scl_pull <= 1'b1;
  endtask
  task automatic stop;
    wait_cyc(LO_CYC / 2);
    sda_pull <= 1'b1;
    wait_cyc(LO_CYC / 2);
    rise_scl();
    wait_cyc(hi_cyc / 2);
    sda_pull <= 1'b0;
    wait_cyc(LO_CYC);
  endtask
  task automatic bit_io(input logic b, output logic r);
    wait_cyc(LO_CYC / 2);
    sda_pull <= ~b;
    wait_cyc(LO_CYC / 2);
    rise_scl();
    wait_cyc(hi_cyc - 2);
    @(negedge core_clk);
    r = sda;
    @(posedge core_clk);
    scl_pull <= 1'b1;
  endtask
  task automatic xfer_byte(input logic [7:0] d, input logic ack_in,
                           output logic [7:0] q, output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
endmodule

`default_nettype wire

// ==== dv/tap_i2c_slave_bench.sv ====
// Self-checking bench for the two-wire slave port.
`timescale 1ns/1ps
`default_nettype none

module tap_i2c_slave_bench;
  import tap_pkg::*;
  logic       core_clk = 0, rst_n = 0, scl_in, sda_in, scl_pull, sda_pull;
  logic       scl_oe, scl_out, sda_oe, sda_out, rx_valid, tx_ready, tx_on = 0;
  logic       addr_select_hi_pin = 0, addr_select_lo_pin = 0, tx_valid = 0;
  logic       xfer_start, xfer_end, selected, read_mode, hs_mode;
  logic [7:0] rx_data, tx_data = 0, q, rxq[$], txq[$], wq[$], rdq[$];
  logic       ak;
  int         fails = 0, compares = 0;

  always #10 core_clk = ~core_clk;
  assign scl_in = ~(scl_oe | scl_pull);
  assign sda_in = ~(sda_oe | sda_pull);
  tap_i2c_slave i_tap_i2c_slave (.*);
  tap_master_model i_tap_master_model (.core_clk(core_clk), .scl(scl_in), .sda(sda_in),
                                       .scl_pull(scl_pull), .sda_pull(sda_pull));
  always @(negedge core_clk) begin
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  always begin
    @(posedge core_clk);
    if (tx_on) begin
      repeat ($urandom_range(40)) @(posedge core_clk);
      tx_data  <= 8'($urandom);
      tx_valid <= 1'b1;
      do @(negedge core_clk); while (tx_ready !== 1'b1 && tx_on);
      if (tx_ready === 1'b1) txq.push_back(tx_data);
      @(posedge core_clk);
      tx_valid <= 1'b0;
    end
  end

  task automatic check_bit(string what, logic exp, logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_byte(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_q(ref logic [7:0] e[$], ref logic [7:0] g[$]);
    check_byte("byte count", 8'(e.size()), 8'(g.size()));
    while (e.size() > 0 && g.size() > 0) check_byte("byte", e.pop_front(), g.pop_front());
    e.delete();
    g.delete();
  endtask
  function automatic logic exp_ack(logic [7:0] a);
    return a[7:1] === {ADDR_FIXED, addr_select_hi_pin, addr_select_lo_pin};
  endfunction
  task automatic send_addr(input logic [7:0] a);
    i_tap_master_model.xfer_byte(a, 1'b1, q, ak);
    check_bit("address ack", !exp_ack(a), ak);
  endtask
  task automatic write_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      wq.push_back(8'($urandom));
      i_tap_master_model.xfer_byte(wq[$], 1'b1, q, ak);
      check_bit("data ack", 1'b0, ak);
    end
  endtask
  task automatic read_bytes(input int n);
    tx_on = 1'b1;
    for (int i = 0; i < n; i++) begin
      i_tap_master_model.xfer_byte(8'hff, i == n - 1, q, ak);
      rdq.push_back(q);
    end
    tx_on = 1'b0;
    repeat (10) @(negedge core_clk);
    check_bit("release after nack", 1'b0, sda_oe);
    check_bit("clock release after nack", 1'b0, scl_oe);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    fails++;
    $display("Error watchdog expected finish seen hang");
    stop_test();
  end
  initial begin
    void'($urandom(5770));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    for (int k = 0; k < 4; k++) begin
      {addr_select_hi_pin, addr_select_lo_pin} <= 2'(k);
      @(posedge core_clk);
      i_tap_master_model.start();
      send_addr({ADDR_FIXED, 2'(k), 1'b0});
      write_bytes(1 + $urandom_range(3));
      i_tap_master_model.stop();
      i_tap_master_model.start();
      send_addr({ADDR_FIXED, 2'(~k), 1'b0});
      i_tap_master_model.stop();
      cmp_q(wq, rxq);
      i_tap_master_model.start();
      send_addr({ADDR_FIXED, 2'(k), 1'b1});
      check_bit("read mode", 1'b1, read_mode);
      read_bytes(2 + k);
      i_tap_master_model.stop();
      cmp_q(txq, rdq);
    end
    i_tap_master_model.start();
    send_addr({MCODE_PFX, 3'($urandom)});
    i_tap_master_model.set_hs(1'b1);
    i_tap_master_model.start();
    repeat (6) @(negedge core_clk);
    check_bit("high speed on", 1'b1, hs_mode);
    send_addr({ADDR_FIXED, addr_select_hi_pin, addr_select_lo_pin, 1'b0});
    write_bytes(2);
    i_tap_master_model.start();
    repeat (6) @(negedge core_clk);
    check_bit("high speed kept", 1'b1, hs_mode);
    send_addr({ADDR_FIXED, addr_select_hi_pin, addr_select_lo_pin, 1'b1});
    read_bytes(2);
    i_tap_master_model.stop();
    i_tap_master_model.set_hs(1'b0);
    repeat (10) @(negedge core_clk);
    check_bit("high speed off", 1'b0, hs_mode);
    cmp_q(wq, rxq);
    cmp_q(txq, rdq);
    stop_test();
  end
endmodule

`default_nettype wire
